// *** uif_map.vh ***
// Register map, field positions, reset values and trigger levels
// of the serial channel front end.
// Assumes inclusion by bare name from the channel modules.
`ifndef UIF_MAP_VH
`define UIF_MAP_VH

// --------------------------------------------------------------
// Register offsets within the 8-byte block
// --------------------------------------------------------------
`define UIF_OFS_DATA      3'h0
`define UIF_OFS_MASK      3'h1
`define UIF_OFS_IDENT     3'h2
`define UIF_OFS_LINE      3'h3

// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define UIF_LFC_DIVACC    7
`define UIF_MSK_RXDATA    0
`define UIF_MSK_TXEMPTY   1
`define UIF_MSK_RXERR     2
`define UIF_MSK_MODEM     3
`define UIF_MSK_XOFF      4
`define UIF_MSK_RTSDTR    5
`define UIF_MSK_CTSDSR    6
`define UIF_QC_ENABLE     0
`define UIF_QC_RXFLUSH    1
`define UIF_QC_TXFLUSH    2
`define UIF_QC_TXTRIG_LO  4
`define UIF_QC_TXTRIG_HI  5
`define UIF_QC_RXTRIG_LO  6
`define UIF_QC_RXTRIG_HI  7

// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define UIF_RST_RXHOLD    8'h00
`define UIF_RST_MASK      8'h00
`define UIF_RST_IDENT     8'hc1
`define UIF_RST_LINE      8'h03
`define UIF_RST_DIV       8'h00
`define UIF_RST_SAMPLE    8'h00
`define UIF_RST_TRIG      2'h0

// --------------------------------------------------------------
// Identification codes, highest priority first
// --------------------------------------------------------------
`define UIF_ID_RXERR      8'hc6
`define UIF_ID_RXDATA     8'hc4
`define UIF_ID_RXTMO      8'hcc
`define UIF_ID_TXEMPTY    8'hc2
`define UIF_ID_MODEM      8'hc0
`define UIF_ID_XOFF       8'hd0
`define UIF_ID_FLOW       8'he0
`define UIF_ID_NONE       8'hc1

// --------------------------------------------------------------
// Trigger levels in characters
// --------------------------------------------------------------
`define UIF_RXTRIG_N0     8'h01
`define UIF_RXTRIG_N1     8'h04
`define UIF_RXTRIG_N2     8'h08
`define UIF_RXTRIG_N3     8'h0e
`define UIF_RXTRIG_E0     8'h0f
`define UIF_RXTRIG_E1     8'h1f
`define UIF_RXTRIG_E2     8'h3f
`define UIF_RXTRIG_E3     8'h6f
`define UIF_TXTRIG_E0     8'h10
`define UIF_TXTRIG_E1     8'h20
`define UIF_TXTRIG_E2     8'h40
`define UIF_TXTRIG_E3     8'h70

`endif

// *** uif_fifo.v ***
// Character queue with flush and a single-entry limit.
// Assumes one clock and a synchronised active-low reset.
module uif_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 128,
    parameter AW    = 7
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             flush,
    input  wire             limitOne,
    input  wire             push,
    input  wire [WIDTH-1:0] pushData,
    input  wire             pop,
    output wire [WIDTH-1:0] headData,
    output wire [AW:0]      count,
    output wire             full,
    output wire             empty
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_r;
    reg [AW-1:0]    rdPtr_r;
    reg [AW:0]      count_r;
    wire            doPush;
    wire            doPop;

    // --------------------------------------------------------------
    // Status and handshake
    // --------------------------------------------------------------
    assign count    = count_r;
    assign empty    = (count_r == {(AW+1){1'b0}});
    assign full     = limitOne ? !empty
                               : (count_r == DEPTH[AW:0]);
    assign doPush   = push && !full;
    assign doPop    = pop && !empty;
    assign headData = mem[rdPtr_r];

    // Storage array, no reset needed
    always @(posedge clk) begin
        if (doPush) begin
            mem[wrPtr_r] <= pushData;
        end
    end

    // Pointers and occupancy; flush empties the queue
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_r <= {AW{1'b0}};
            rdPtr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else if (flush) begin
            wrPtr_r <= {AW{1'b0}};
            rdPtr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (doPush) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (doPop) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
            if (doPush && !doPop) begin
                count_r <= count_r + 1'b1;
            end else if (doPop && !doPush) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule

// *** uif_ctrl.v ***
// Host register front end of one serial channel: holding stages,
// interrupt mask and identification, queue control, divisor access.
// Assumes the serializer, line status and modem logic sit beside it
// on the same clock and present their pending conditions as levels.
`include "uif_map.vh"

module uif_ctrl #(
    parameter DEPTH = 128,
    parameter AW    = 7
) (
    input  wire       sys_clk,
    input  wire       arst_n,
    input  wire [2:0] regAddr,
    input  wire       regWr,
    input  wire       regRd,
    input  wire [7:0] regWrData,
    output wire [7:0] regRdData,
    input  wire       rxValid,
    input  wire [7:0] rxData,
    output wire       rxReady,
    output wire       txValid,
    output wire [7:0] txData,
    input  wire       txReady,
    input  wire       rxErrPend,
    input  wire       rxTimeoutPend,
    input  wire       modemPend,
    input  wire       xoffPend,
    input  wire       rtsDtrPend,
    input  wire       ctsDsrPend,
    input  wire       enhancedMode,
    output wire       irqOut,
    output wire       queueMode,
    output wire [7:0] lineFormat,
    output wire [7:0] divisorLow,
    output wire [7:0] divisorHigh,
    output wire [7:0] sampleClock
);

    // --------------------------------------------------------------
    // Trigger decode, shared by both directions
    // --------------------------------------------------------------
    function [7:0] trigLevel;
        input [1:0] sel;
        input       isRx;
        input       enh;
        begin
            case ({isRx, enh, sel})
                4'b1000: trigLevel = `UIF_RXTRIG_N0;
                4'b1001: trigLevel = `UIF_RXTRIG_N1;
                4'b1010: trigLevel = `UIF_RXTRIG_N2;
                4'b1011: trigLevel = `UIF_RXTRIG_N3;
                4'b1100: trigLevel = `UIF_RXTRIG_E0;
                4'b1101: trigLevel = `UIF_RXTRIG_E1;
                4'b1110: trigLevel = `UIF_RXTRIG_E2;
                4'b1111: trigLevel = `UIF_RXTRIG_E3;
                4'b0100: trigLevel = `UIF_TXTRIG_E0;
                4'b0101: trigLevel = `UIF_TXTRIG_E1;
                4'b0110: trigLevel = `UIF_TXTRIG_E2;
                4'b0111: trigLevel = `UIF_TXTRIG_E3;
                default: trigLevel = 8'h00;
            endcase
        end
    endfunction

    // --------------------------------------------------------------
    // Declarations
    // --------------------------------------------------------------
    reg        rstMeta_r;
    reg        rstSync_r;
    wire       rstSync_n;
    reg  [7:0] irqMask_r;
    reg  [7:0] lineFmt_r;
    reg  [7:0] divLow_r;
    reg  [7:0] divHigh_r;
    reg  [7:0] sample_r;
    reg        queueEn_r;
    reg  [1:0] txTrig_r;
    reg  [1:0] rxTrig_r;
    reg  [7:0] rdData_r;
    reg  [7:0] rdData_nxt;
    reg        irq_r;
    reg  [7:0] ident_nxt;
    wire       divAccess;
    wire       wrData;
    wire       wrMask;
    wire       wrQueue;
    wire       wrLine;
    wire       rdData;
    wire       modeChange;
    wire       rxFlush;
    wire       txFlush;
    wire       singleChar;
    wire [7:0] rxHead;
    wire [7:0] txHead;
    wire [AW:0] rxCount;
    wire [AW:0] txCount;
    wire       rxFull;
    wire       rxEmpty;
    wire       txFull;
    wire       txEmpty;
    wire [7:0] rxTrigChars;
    wire [7:0] txTrigChars;
    wire [AW:0] txFree;
    wire       rxAvail;
    wire       txLow;
    wire [6:0] srcPend;
    wire [6:0] srcEn;

    // --------------------------------------------------------------
    // Reset release through two flip-flops
    // --------------------------------------------------------------
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end
    assign rstSync_n = rstSync_r;

    // --------------------------------------------------------------
    // Address decode
    // --------------------------------------------------------------
    assign divAccess = lineFmt_r[`UIF_LFC_DIVACC];
    assign wrData    = regWr && (regAddr == `UIF_OFS_DATA);
    assign wrMask    = regWr && (regAddr == `UIF_OFS_MASK);
    assign wrQueue   = regWr && (regAddr == `UIF_OFS_IDENT)
                       && !divAccess;
    assign wrLine    = regWr && (regAddr == `UIF_OFS_LINE);
    assign rdData    = regRd && (regAddr == `UIF_OFS_DATA)
                       && !divAccess;

    // Queue flush pulses, never stored; mode change empties both
    assign modeChange = wrQueue
        && (regWrData[`UIF_QC_ENABLE] != queueEn_r);
    assign rxFlush = (wrQueue && regWrData[`UIF_QC_RXFLUSH])
                     || modeChange;
    assign txFlush = (wrQueue && regWrData[`UIF_QC_TXFLUSH])
                     || modeChange;
    assign singleChar = !queueEn_r;

    // --------------------------------------------------------------
    // Writable registers
    // --------------------------------------------------------------
    always @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            irqMask_r <= `UIF_RST_MASK;
            lineFmt_r <= `UIF_RST_LINE;
            divLow_r  <= `UIF_RST_DIV;
            divHigh_r <= `UIF_RST_DIV;
            sample_r  <= `UIF_RST_SAMPLE;
            queueEn_r <= 1'b0;
            txTrig_r  <= `UIF_RST_TRIG;
            rxTrig_r  <= `UIF_RST_TRIG;
        end else begin
            if (wrData && divAccess) begin
                divLow_r <= regWrData;
            end
            if (wrMask) begin
                if (divAccess) begin
                    divHigh_r <= regWrData;
                end else begin
                    irqMask_r <= regWrData;
                end
            end
            if (regWr && (regAddr == `UIF_OFS_IDENT) && divAccess) begin
                sample_r <= regWrData;
            end
            if (wrLine) begin
                lineFmt_r <= regWrData;
            end
            // Bit 3 is reserved and dropped
            if (wrQueue) begin
                queueEn_r <= regWrData[`UIF_QC_ENABLE];
                txTrig_r  <= regWrData[`UIF_QC_TXTRIG_HI:
                                       `UIF_QC_TXTRIG_LO];
                rxTrig_r  <= regWrData[`UIF_QC_RXTRIG_HI:
                                       `UIF_QC_RXTRIG_LO];
            end
        end
    end

    // --------------------------------------------------------------
    // Receive and transmit queues
    // --------------------------------------------------------------
    uif_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) rxQueue (
        .clk      (sys_clk),
        .rst_n    (rstSync_n),
        .flush    (rxFlush),
        .limitOne (singleChar),
        .push     (rxValid),
        .pushData (rxData),
        .pop      (rdData),
        .headData (rxHead),
        .count    (rxCount),
        .full     (rxFull),
        .empty    (rxEmpty)
    );

    uif_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) txQueue (
        .clk      (sys_clk),
        .rst_n    (rstSync_n),
        .flush    (txFlush),
        .limitOne (singleChar),
        .push     (wrData && !divAccess),
        .pushData (regWrData),
        .pop      (txReady),
        .headData (txHead),
        .count    (txCount),
        .full     (txFull),
        .empty    (txEmpty)
    );

    // Serial side handshakes
    assign rxReady = !rxFull;
    assign txValid = !txEmpty;
    assign txData  = txHead;

    // --------------------------------------------------------------
    // Trigger thresholds and queue-level sources
    // --------------------------------------------------------------
    assign rxTrigChars = trigLevel(rxTrig_r, 1'b1, enhancedMode);
    assign txTrigChars = trigLevel(txTrig_r, 1'b0, enhancedMode);
    assign txFree      = DEPTH[AW:0] - txCount;

    // Thresholds count only with queues on; transmit also needs enhanced mode
    assign rxAvail = queueEn_r
        ? (rxCount >= rxTrigChars[AW:0])
        : !rxEmpty;
    assign txLow = (queueEn_r && enhancedMode)
        ? (txFree >= txTrigChars[AW:0])
        : txEmpty;

    // Pending sources indexed by mask bit
    assign srcPend[`UIF_MSK_RXDATA]  = rxAvail || rxTimeoutPend;
    assign srcPend[`UIF_MSK_TXEMPTY] = txLow;
    assign srcPend[`UIF_MSK_RXERR]   = rxErrPend;
    assign srcPend[`UIF_MSK_MODEM]   = modemPend;
    assign srcPend[`UIF_MSK_XOFF]    = xoffPend;
    assign srcPend[`UIF_MSK_RTSDTR]  = rtsDtrPend;
    assign srcPend[`UIF_MSK_CTSDSR]  = ctsDsrPend;

    // Mask gating, one bit per source
    genvar g;
    generate
        for (g = 0; g < 7; g = g + 1) begin : gateSrc
            assign srcEn[g] = srcPend[g] && irqMask_r[g];
        end
    endgenerate

    // --------------------------------------------------------------
    // Priority encoder for identification
    // --------------------------------------------------------------
    always @* begin
        if (srcEn[`UIF_MSK_RXERR]) begin
            ident_nxt = `UIF_ID_RXERR;
        end else if (irqMask_r[`UIF_MSK_RXDATA] && rxAvail) begin
            ident_nxt = `UIF_ID_RXDATA;
        end else if (irqMask_r[`UIF_MSK_RXDATA] && rxTimeoutPend) begin
            ident_nxt = `UIF_ID_RXTMO;
        end else if (srcEn[`UIF_MSK_TXEMPTY]) begin
            ident_nxt = `UIF_ID_TXEMPTY;
        end else if (srcEn[`UIF_MSK_MODEM]) begin
            ident_nxt = `UIF_ID_MODEM;
        end else if (srcEn[`UIF_MSK_XOFF]) begin
            ident_nxt = `UIF_ID_XOFF;
        end else if (srcEn[`UIF_MSK_RTSDTR]
                     || srcEn[`UIF_MSK_CTSDSR]) begin
            ident_nxt = `UIF_ID_FLOW;
        end else begin
            ident_nxt = `UIF_ID_NONE;
        end
    end

    // --------------------------------------------------------------
    // Read data mux
    // --------------------------------------------------------------
    always @* begin
        case (regAddr)
            `UIF_OFS_DATA: begin
                if (divAccess) begin
                    rdData_nxt = divLow_r;
                end else if (rxEmpty) begin
                    rdData_nxt = `UIF_RST_RXHOLD;
                end else begin
                    rdData_nxt = rxHead;
                end
            end
            `UIF_OFS_MASK: begin
                rdData_nxt = divAccess ? divHigh_r : irqMask_r;
            end
            `UIF_OFS_IDENT: begin
                rdData_nxt = divAccess ? sample_r
                                       : ident_nxt;
            end
            `UIF_OFS_LINE: begin
                rdData_nxt = lineFmt_r;
            end
            default: begin
                rdData_nxt = 8'h00;
            end
        endcase
    end

    // Read data register; holds between reads
    always @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            rdData_r <= `UIF_RST_IDENT & 8'h00;
        end else if (regRd) begin
            rdData_r <= rdData_nxt;
        end
    end

    // --------------------------------------------------------------
    // Interrupt output
    // --------------------------------------------------------------
    always @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |srcEn;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign regRdData   = rdData_r;
    assign irqOut      = irq_r;
    assign queueMode   = queueEn_r;
    assign lineFormat  = lineFmt_r;
    assign divisorLow  = divLow_r;
    assign divisorHigh = divHigh_r;
    assign sampleClock = sample_r;

endmodule

// *** uif_dummy_unused.v ***
// Not used.

// *** uif_ctrl_monitor.sv ***
// Port checker for the serial channel register front end.
// Assumes it is bound to uif_ctrl and sees only its ports.
module uif_ctrl_monitor (
    input wire logic       sys_clk,
    input wire logic       arst_n,
    input wire logic [2:0] regAddr,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic       rxValid,
    input wire logic       rxReady,
    input wire logic       txValid,
    input wire logic       rxErrPend,
    input wire logic       rxTimeoutPend,
    input wire logic       modemPend,
    input wire logic       xoffPend,
    input wire logic       rtsDtrPend,
    input wire logic       ctsDsrPend,
    input wire logic       irqOut,
    input wire logic       queueMode,
    input wire logic [7:0] lineFormat,
    input wire logic [7:0] sampleClock
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] maskSh_r;
    logic       qcWr_r;
    logic       qcBit_r;
    wire        dataSel = !lineFormat[7];
    // Shadow of mask writes and of queue control writes
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            maskSh_r <= 8'h00;
            qcWr_r   <= 1'b0;
            qcBit_r  <= 1'b0;
        end else begin
            if (regWr && regAddr == 3'h1 && dataSel) begin
                maskSh_r <= regWrData;
            end
            qcWr_r  <= regWr && regAddr == 3'h2 && dataSel;
            qcBit_r <= regWrData[0];
        end
    end
    default clocking mcb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // ----------------------------------------------------------
    // Checks
    // ----------------------------------------------------------
    a_rdata_hold: assert property (!regRd |=> $stable(regRdData))
        else $error("read data moved without a read");
    a_mask_readback: assert property (regRd && regAddr == 3'h1
        && dataSel && !regWr |=> regRdData == maskSh_r)
        else $error("mask read back wrong");
    a_ident_idle: assert property (regRd && regAddr == 3'h2
        && dataSel && maskSh_r == 8'h00 |=> regRdData == 8'hc1)
        else $error("ident not idle with mask clear");
    a_ident_err: assert property (regRd && regAddr == 3'h2
        && dataSel && rxErrPend && maskSh_r[2] |=> regRdData == 8'hc6)
        else $error("receive error not top priority");
    a_irq_raise: assert property (rxErrPend && maskSh_r[2]
        |=> irqOut)
        else $error("interrupt missing");
    a_irq_drop: assert property (!(rxErrPend || rxTimeoutPend
        || modemPend || xoffPend || rtsDtrPend || ctsDsrPend)
        && maskSh_r[1:0] == 2'h0 |=> !irqOut)
        else $error("interrupt without enabled source");
    a_tx_push: assert property (regWr && regAddr == 3'h0
        && dataSel && !txValid |=> txValid)
        else $error("written character not queued");
    a_rx_single: assert property (!queueMode && rxValid
        && rxReady && !regRd && !regWr |=> !rxReady)
        else $error("more than one character with queues off");
    a_divacc_read: assert property (regRd && regAddr == 3'h2
        && !dataSel && !regWr |=> regRdData == sampleClock)
        else $error("divisor access read wrong");
    a_mode_write: assert property (qcWr_r |-> queueMode == qcBit_r)
        else $error("queue enable not taken");
    c_err_ident: cover property (regRd && regAddr == 3'h2 && rxErrPend);
    c_irq_rise: cover property ($rose(irqOut));
    c_div_read: cover property (regRd && lineFormat[7]);
endmodule

bind uif_ctrl uif_ctrl_monitor u_uif_ctrl_monitor (
    .sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr), .regWr(regWr),
    .regRd(regRd), .regWrData(regWrData), .regRdData(regRdData),
    .rxValid(rxValid), .rxReady(rxReady), .txValid(txValid),
    .rxErrPend(rxErrPend), .rxTimeoutPend(rxTimeoutPend),
    .modemPend(modemPend), .xoffPend(xoffPend), .rtsDtrPend(rtsDtrPend),
    .ctsDsrPend(ctsDsrPend), .irqOut(irqOut), .queueMode(queueMode),
    .lineFormat(lineFormat), .sampleClock(sampleClock)
);

// *** uif_peer_model.sv ***
// Remote serial device: offers received characters, takes sent ones.
// Assumes the valid and ready handshakes of uif_ctrl, one clock.
module uif_peer_model (
    input wire logic       clk,
    input wire logic       stall,
    output logic           rxValid,
    output logic [7:0]     rxData,
    input wire logic       rxReady,
    input wire logic       txValid,
    input wire logic [7:0] txData,
    output logic           txReady
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sendQ[$];
    logic [7:0] got[$];
    initial begin
        rxValid = 1'b0;
        rxData  = 8'h00;
        txReady = 1'b0;
    end
    task send(input logic [7:0] d);
        sendQ.push_back(d);
    endtask
    // Hold a character until taken; scramble the data when idle
    always @(posedge clk) begin
        if (rxValid && rxReady) begin
            void'(sendQ.pop_front());
        end
        if (sendQ.size() > 0) begin
            rxValid <= 1'b1;
            rxData  <= sendQ[0];
        end else begin
            rxValid <= 1'b0;
            rxData  <= ~rxData;
        end
        if (txValid && txReady) begin
            got.push_back(txData);
        end
        txReady <= !stall;
    end
endmodule

// *** uif_ctrl_tb.sv ***
// Self-checking bench for the serial channel register front end.
// Assumes uif_ctrl, its monitor and the remote device model.
module uif_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       sys_clk, arst_n, regWr, regRd, rxValid, rxReady, txValid;
    logic       txReady, enhancedMode, irqOut, queueMode, stall;
    logic [2:0] regAddr;
    logic [7:0] regWrData, regRdData, rxData, txData, lineFormat;
    logic [7:0] divisorLow, divisorHigh, sampleClock;
    logic [5:0] pendV;
    logic [7:0] rxQ[$], txQ[$];
    int         num_errors, n_checks, maskM, lfM, lvl;
    integer     seed;

    uif_ctrl u_uif_ctrl (
        .sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWr(regWr), .regRd(regRd), .regWrData(regWrData),
        .regRdData(regRdData), .rxValid(rxValid), .rxData(rxData),
        .rxReady(rxReady), .txValid(txValid), .txData(txData),
        .txReady(txReady), .rxErrPend(pendV[0]), .rxTimeoutPend(pendV[1]),
        .modemPend(pendV[2]), .xoffPend(pendV[3]), .rtsDtrPend(pendV[4]),
        .ctsDsrPend(pendV[5]), .enhancedMode(enhancedMode), .irqOut(irqOut),
        .queueMode(queueMode), .lineFormat(lineFormat),
        .divisorLow(divisorLow), .divisorHigh(divisorHigh),
        .sampleClock(sampleClock)
    );
    uif_peer_model u_uif_peer_model (
        .clk(sys_clk), .stall(stall), .rxValid(rxValid), .rxData(rxData),
        .rxReady(rxReady), .txValid(txValid), .txData(txData),
        .txReady(txReady)
    );

    // ----------------------------------------------------------
    // Reference model and bus tasks
    // ----------------------------------------------------------
    // Expected ident code, highest priority first
    function automatic logic [7:0] identM(int rxc, int trig, bit txe);
        if (pendV[0] && maskM[2]) return 8'hc6;
        if (rxc >= trig && maskM[0]) return 8'hc4;
        if (pendV[1] && maskM[0]) return 8'hcc;
        if (txe && maskM[1]) return 8'hc2;
        if (pendV[2] && maskM[3]) return 8'hc0;
        if (pendV[3] && maskM[4]) return 8'hd0;
        if ((pendV[4] && maskM[5]) || (pendV[5] && maskM[6])) return 8'he0;
        return 8'hc1;
    endfunction
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
        if (a == 3'h3) lfM = d[7];
        else if (lfM == 0 && a == 3'h1) maskM = d;
        else if (lfM == 0 && a == 3'h0) txQ.push_back(d);
    endtask
    task rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 chk(regRdData, exp);
    endtask
    // Remote device sends n random characters, then settle
    task feed(input int n);
        logic [7:0] d;
        repeat (n) begin
            d = 8'($random(seed));
            u_uif_peer_model.send(d);
            rxQ.push_back(d);
        end
        repeat (n + 4) @(posedge sys_clk);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Clock and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        #(50 * 20000);
        num_errors++;
        wrap_up;
    end

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    initial begin
        seed = 14350;
        arst_n = 1'b0;
        {regWr, regRd, regAddr, regWrData} = '0;
        {enhancedMode, stall, pendV, maskM, lfM} = '0;
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(3'h0, 8'h00);
        rd(3'h1, 8'h00);
        rd(3'h2, 8'hc1);
        $display("test reset done");
        repeat (24) begin
            pendV <= 6'($random(seed));
            wr(3'h1, 8'($random(seed)));
            rd(3'h1, maskM[7:0]);
            rd(3'h2, identM(0, 1, 1));
            chk({7'h0, irqOut}, {7'h0, identM(0, 1, 1) != 8'hc1});
        end
        pendV <= 6'h00;
        wr(3'h1, 8'h00);
        $display("test priority done");
        feed(2);
        rd(3'h0, rxQ.pop_front());
        repeat (3) @(posedge sys_clk);
        rd(3'h0, rxQ.pop_front());
        rd(3'h0, 8'h00);
        $display("test single done");
        for (int t = 0; t < 2; t++) begin
            lvl = t ? 15 : 4;
            enhancedMode <= t[0];
            wr(3'h2, t ? 8'h01 : 8'h41);
            wr(3'h1, 8'h01);
            feed(lvl - 1);
            rd(3'h2, identM(lvl - 1, lvl, 0));
            feed(1);
            rd(3'h2, identM(lvl, lvl, 0));
            if (t == 0) begin
                wr(3'h2, 8'h43);
                rxQ.delete();
                rd(3'h0, 8'h00);
            end
            while (rxQ.size() > 0) rd(3'h0, rxQ.pop_front());
            rd(3'h2, identM(0, lvl, 0));
        end
        $display("test queue done");
        stall <= 1'b1;
        wr(3'h2, 8'h31);
        wr(3'h1, 8'h02);
        for (int i = 1; i <= 17; i++) begin
            wr(3'h0, 8'($random(seed)));
            if (i >= 16) rd(3'h2, identM(0, 1, i <= 16));
        end
        wr(3'h2, 8'h35);
        txQ.delete();
        #1 chk({7'h0, txValid}, 8'h00);
        repeat (3) wr(3'h0, 8'($random(seed)));
        stall <= 1'b0;
        repeat (10) @(posedge sys_clk);
        chk(8'(u_uif_peer_model.got.size()), 8'h03);
        foreach (txQ[i]) chk(u_uif_peer_model.got[i], txQ[i]);
        $display("test transmit done");
        wr(3'h3, 8'h83);
        for (int i = 0; i < 3; i++) wr(i[2:0], 8'ha0 + i[7:0]);
        for (int i = 0; i < 3; i++) rd(i[2:0], 8'ha0 + i[7:0]);
        chk(divisorHigh, 8'ha1);
        chk(divisorLow, 8'ha0);
        chk(lineFormat, 8'h83);
        chk({7'h0, txValid}, 8'h00);
        chk({7'h0, queueMode}, 8'h01);
        wr(3'h3, 8'h03);
        rd(3'h1, maskM[7:0]);
        $display("test divisor done");
        wrap_up;
    end
endmodule
